// File: pkg/fault_pkg.sv
// Notes on behaviour
// - Gate off at once when sense exceeds peak limit, limit chosen by line.
// - Supply above clamp level turns on the supply sink.
// - Supply overvoltage held 150 us latches fault: one hiccup plus clearance.
// - Feedback sampled 750 ns after turn-off; four high samples latch one-hiccup fault.
// - Feedback undervoltage held 56 ms latches output short, four hiccups.
// - Sense low with compensation high for 56 ms: eight hiccups plus clearance.
// - Sense pin sourced; open level seen latches one-hiccup fault plus clearance.
// - Compensation above overload level for 210 ms latches four-hiccup fault.
// - Sense above level inside blanking on seven cycles: eight-hiccup fault.
// - Sense sampled 1.5 us after turn-off; 32 high samples: one hiccup.
// - Thermal flag stops switching until cooled report or supply restart.
// - AC mode: 28 consecutive haversines reaching peak limit give eight-hiccup fault.
// - Line overvoltage held 150 us latches one-hiccup fault plus clearance.
// - Peak-limit sense comparisons ignored for 460 ns after each turn-on.
// - Feedback overvoltage level chosen from sense resistor set during setting phase.
package fault_pkg;
  localparam int CLK_NS = 10;
  localparam int BLANK_NS = 460;
  localparam int FB_SAMPLE_NS = 750;
  localparam int OTP_SAMPLE_NS = 1500;
  localparam int SUPPLY_OV_NS = 150000;
  localparam int LINE_OV_NS = 150000;
  localparam int FB_UV_NS = 56000000;
  localparam int SHORT_NS = 56000000;
  localparam int OVERLOAD_NS = 210000000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FB_SAMPLE_CYC = (FB_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OTP_SAMPLE_CYC = (OTP_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUPPLY_OV_CYC = (SUPPLY_OV_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINE_OV_CYC = (LINE_OV_NS + CLK_NS - 1) / CLK_NS;
  localparam int FB_UV_CYC = (FB_UV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_CYC = (SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OVERLOAD_CYC = (OVERLOAD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] FB_OV_COUNT = 6'h04;
  localparam logic [5:0] DIODE_COUNT = 6'h07;
  localparam logic [5:0] OTP_COUNT = 6'h20;
  localparam logic [5:0] HAV_COUNT = 6'h1c;
  localparam int NFAULT = 10;
  localparam int NDEB = 5;
  // Fault index: 0 supply ov, 1 fb uv, 2 sense short, 3 overload, 4 line ov,
  // 5 fb ov, 6 diode short, 7 external overtemp, 8 haversine oc, 9 sense open
  localparam logic [NFAULT-1:0][3:0] HICCUPS = {4'h1, 4'h8, 4'h1, 4'h8, 4'h1,
                                                4'h1, 4'h4, 4'h8, 4'h4, 4'h1};
  localparam logic [NFAULT-1:0] NEED_CLEAR = 10'h235;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [10:0] MASK_RESET = 11'h000;
  localparam logic [7:0] OFF_IDLE = 8'hff;
endpackage : fault_pkg

// File: rtl/power_stage_fault_manager.sv
`timescale 1ns/100ps
module power_stage_fault_manager #(
  parameter int SUPPLY_OV_CYC = fault_pkg::SUPPLY_OV_CYC,
  parameter int LINE_OV_CYC = fault_pkg::LINE_OV_CYC,
  parameter int FB_UV_CYC = fault_pkg::FB_UV_CYC,
  parameter int SHORT_CYC = fault_pkg::SHORT_CYC,
  parameter int OVERLOAD_CYC = fault_pkg::OVERLOAD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_request,
  input wire logic high_line,
  input wire logic cs_above_max,
  input wire logic cs_above_min,
  input wire logic supply_above_clamp,
  input wire logic supply_above_ov,
  input wire logic fb_above_ov_a,
  input wire logic fb_above_ov_b,
  input wire logic fb_below_uv,
  input wire logic cs_below_short,
  input wire logic comp_above_2v,
  input wire logic cs_above_open,
  input wire logic comp_above_overload,
  input wire logic cs_above_otp,
  input wire logic thermal_hot,
  input wire logic thermal_cooled,
  input wire logic haversine_end,
  input wire logic line_overvoltage,
  input wire logic uvlo_ok,
  input wire logic setting_phase,
  input wire logic sense_set_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic gate_on,
  output logic supply_sink_en,
  output logic sense_source_en,
  output logic irq
);
  import fault_pkg::*;

  localparam logic [NDEB-1:0][31:0] DEB_LIM = {32'(OVERLOAD_CYC), 32'(SHORT_CYC),
    32'(LINE_OV_CYC), 32'(FB_UV_CYC), 32'(SUPPLY_OV_CYC)};

  logic gate_r;
  logic gate_nxt;
  logic trip_r;
  logic [7:0] blank_cnt_r;
  logic [7:0] off_cnt_r;
  logic blank_done;
  logic limit_hit;
  logic fb_sel_b_r;
  logic fb_ov_cond;
  logic [5:0] fbov_cnt_r;
  logic [5:0] diode_cnt_r;
  logic [5:0] otp_cnt_r;
  logic [5:0] hav_cnt_r;
  logic diode_seen_r;
  logic hav_mark_r;
  logic [NFAULT-1:0] trig;
  logic [NFAULT-1:0] raw;
  logic [NFAULT-1:0] cause_r;
  logic [3:0] need_r;
  logic [3:0] need_nxt;
  logic [3:0] hic_cnt_r;
  logic hold_r;
  logic release_ok;
  logic uvlo_prev_r;
  logic restart;
  logic thermal_r;
  logic ac_mode_r;
  logic [10:0] irq_stat_r;
  logic [10:0] irq_stat_nxt;
  logic [10:0] irq_mask_r;
  logic [10:0] events;
  logic [NDEB-1:0] deb_cond;
  logic [NDEB-1:0] deb_trig;
  logic bus_done;

  // low line uses the higher limit
  assign limit_hit = high_line ? cs_above_min : cs_above_max;
  assign blank_done = blank_cnt_r == 8'(BLANK_CYC);
  assign fb_ov_cond = fb_sel_b_r ? fb_above_ov_b : fb_above_ov_a;
  assign restart = uvlo_ok && !uvlo_prev_r;

  always_comb begin
    gate_nxt = pwm_request && !hold_r && !thermal_r && !trip_r && !(|trig);
    if (gate_r && blank_done && limit_hit) begin
      gate_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // Trip holds off until the regulator ends its on request
  always_ff @(posedge clk) begin
    if (rst) begin
      trip_r <= 1'b0;
    end else if (!pwm_request) begin
      trip_r <= 1'b0;
    end else if (gate_r && blank_done && limit_hit) begin
      trip_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !gate_r) begin
      blank_cnt_r <= 8'h00;
    end else if (!blank_done) begin
      blank_cnt_r <= blank_cnt_r + 8'h01;
    end
  end

  // Idle value keeps samples off until a real turn-off occurs
  always_ff @(posedge clk) begin
    if (rst) begin
      off_cnt_r <= OFF_IDLE;
    end else if (gate_r) begin
      off_cnt_r <= 8'h00;
    end else if (off_cnt_r != OFF_IDLE) begin
      off_cnt_r <= off_cnt_r + 8'h01;
    end
  end

  // level set latched in setting phase
  always_ff @(posedge clk) begin
    if (rst) begin
      fb_sel_b_r <= 1'b0;
    end else if (setting_phase) begin
      fb_sel_b_r <= sense_set_b;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      supply_sink_en <= 1'b0;
      sense_source_en <= 1'b0;
    end else begin
      supply_sink_en <= supply_above_clamp;
      sense_source_en <= 1'b1;
    end
  end

  assign deb_cond = {comp_above_overload, cs_below_short && comp_above_2v,
                     line_overvoltage, fb_below_uv, supply_above_ov};

  generate
    for (genvar i = 0; i < NDEB; i++) begin : g_deb
      logic [31:0] cnt_r;
      assign deb_trig[i] = deb_cond[i] && (cnt_r == DEB_LIM[i] - 32'd1);
      // continuous debounce, restarts on any gap
      always_ff @(posedge clk) begin
        if (rst || !deb_cond[i]) begin
          cnt_r <= 32'h0;
        end else if (cnt_r != DEB_LIM[i]) begin
          cnt_r <= cnt_r + 32'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || fbov_cnt_r == FB_OV_COUNT) begin
      fbov_cnt_r <= 6'h00;
    end else if (off_cnt_r == 8'(FB_SAMPLE_CYC)) begin
      fbov_cnt_r <= fb_ov_cond ? fbov_cnt_r + 6'h01 : 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || otp_cnt_r == OTP_COUNT) begin
      otp_cnt_r <= 6'h00;
    end else if (off_cnt_r == 8'(OTP_SAMPLE_CYC)) begin
      otp_cnt_r <= cs_above_otp ? otp_cnt_r + 6'h01 : 6'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !gate_r) begin
      diode_seen_r <= 1'b0;
    end else if (!blank_done && cs_above_max) begin
      diode_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || diode_cnt_r == DIODE_COUNT) begin
      diode_cnt_r <= 6'h00;
    end else if (gate_r && !gate_nxt) begin
      diode_cnt_r <= diode_seen_r ? diode_cnt_r + 6'h01 : 6'h00;
    end
  end

  // mark per haversine; a hit on the closing cycle still counts
  always_ff @(posedge clk) begin
    if (rst || haversine_end) begin
      hav_mark_r <= 1'b0;
    end else if (limit_hit && gate_r && blank_done) begin
      hav_mark_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !ac_mode_r || hav_cnt_r == HAV_COUNT) begin
      hav_cnt_r <= 6'h00;
    end else if (haversine_end) begin
      hav_cnt_r <= (hav_mark_r || (limit_hit && gate_r && blank_done)) ? hav_cnt_r + 6'h01 : 6'h00;
    end
  end

  assign trig = {cs_above_open, hav_cnt_r == HAV_COUNT, otp_cnt_r == OTP_COUNT,
                 diode_cnt_r == DIODE_COUNT, fbov_cnt_r == FB_OV_COUNT, deb_trig[2],
                 deb_trig[4], deb_trig[3], deb_trig[1], deb_trig[0]};
  assign raw = {cs_above_open, 1'b0, cs_above_otp, 1'b0, fb_ov_cond, line_overvoltage,
                comp_above_overload, cs_below_short && comp_above_2v, fb_below_uv, supply_above_ov};

  // largest hiccup count among latched causes
  always_comb begin
    need_nxt = hold_r ? need_r : 4'h0;
    for (int i = 0; i < NFAULT; i++) begin
      if (trig[i] && HICCUPS[i] > need_nxt) begin
        need_nxt = HICCUPS[i];
      end
    end
  end

  assign release_ok = hic_cnt_r >= need_r && !(|(cause_r & NEED_CLEAR & raw));

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= 1'b0;
      cause_r <= '0;
      need_r <= 4'h0;
      hic_cnt_r <= 4'h0;
    end else if (|trig) begin
      hold_r <= 1'b1;
      cause_r <= (hold_r ? cause_r : '0) | trig;
      need_r <= need_nxt;
      if (hold_r && restart && hic_cnt_r != 4'hf) begin
        hic_cnt_r <= hic_cnt_r + 4'h1;
      end
    end else if (hold_r && release_ok) begin
      hold_r <= 1'b0;
      cause_r <= '0;
      need_r <= 4'h0;
      hic_cnt_r <= 4'h0;
    end else if (hold_r && restart && hic_cnt_r != 4'hf) begin
      hic_cnt_r <= hic_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Supply taken as up in reset, so release is no false restart
      uvlo_prev_r <= 1'b1;
    end else begin
      uvlo_prev_r <= uvlo_ok;
    end
  end

  // thermal stop, hot flag beats the cool report
  always_ff @(posedge clk) begin
    if (rst) begin
      thermal_r <= 1'b0;
    end else if (thermal_hot) begin
      thermal_r <= 1'b1;
    end else if (thermal_cooled || restart) begin
      thermal_r <= 1'b0;
    end
  end

  // One wait cycle per access, then waitrequest drops for exactly one edge
  assign bus_done = (read || write) && !waitrequest;

  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (read || write) begin
      waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (read && waitrequest) begin
      if (address == ADDR_CTRL) begin
        readdata <= {31'h0, ac_mode_r};
      end else if (address == ADDR_STATUS) begin
        readdata <= {15'h0, fb_sel_b_r, hic_cnt_r, thermal_r, hold_r, cause_r};
      end else if (address == ADDR_IRQ_STAT) begin
        readdata <= {21'h0, irq_stat_r};
      end else if (address == ADDR_IRQ_MASK) begin
        readdata <= {21'h0, irq_mask_r};
      end else begin
        readdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ac_mode_r <= CTRL_RESET[0];
      irq_mask_r <= MASK_RESET;
    end else if (write && !waitrequest) begin
      if (address == ADDR_CTRL) begin
        ac_mode_r <= writedata[0];
      end else if (address == ADDR_IRQ_MASK) begin
        irq_mask_r <= writedata[10:0];
      end
    end
  end

  assign events = {thermal_hot && !thermal_r, trig};

  // Read clears, but an event in the same cycle is kept
  always_comb begin
    irq_stat_nxt = irq_stat_r | events;
    if (read && !waitrequest && address == ADDR_IRQ_STAT) begin
      irq_stat_nxt = events;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  assign gate_on = gate_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_peak_over;
    gate_r && blank_done && limit_hit;
  endsequence

  sequence s_gate_low_two;
    !gate_r ##1 !gate_r;
  endsequence

  a_peak_gate_off: assert property (s_peak_over |=> s_gate_low_two)
    else $error("gate not cut after peak limit");
  a_clamp_sink_on: assert property (supply_above_clamp |=> supply_sink_en)
    else $error("sink not enabled at clamp");
  a_supply_ov_latch: assert property (deb_trig[0] |=> hold_r && cause_r[0] && need_r >= 4'h1)
    else $error("supply overvoltage not latched");
  a_fbov_four_samples: assert property (fbov_cnt_r == FB_OV_COUNT |=> hold_r && cause_r[5])
    else $error("feedback overvoltage not latched");
  a_short_eight_hiccups: assert property (deb_trig[3] |=> need_r == 4'h8)
    else $error("sense short hiccup count wrong");
  a_open_latch: assert property (cs_above_open |=> hold_r && !gate_r)
    else $error("sense open not latched");
  a_thermal_stop: assert property (thermal_hot |=> thermal_r ##1 !gate_r)
    else $error("switching not stopped when hot");
  a_blank_no_trip: assert property ($rose(gate_r) |-> !trip_r [*3])
    else $error("trip inside blanking");
  a_fb_level_pick: assert property (setting_phase && sense_set_b |=> fb_sel_b_r)
    else $error("feedback level set not captured");
  a_hold_release: assert property ($fell(hold_r) |-> $past(hic_cnt_r) >= $past(need_r))
    else $error("released before enough hiccups");
  a_hold_gate_low: assert property (hold_r |=> !gate_r)
    else $error("gate on while fault held");
endmodule : power_stage_fault_manager

// File: dv/power_stage_model.sv
`timescale 1ns/100ps
module power_stage_model (
  input wire logic clk,
  input wire logic gate_on,
  input wire logic [7:0] ramp_cyc,
  output logic cs_above_max,
  output logic cs_above_min
);
  logic [7:0] on_cnt_r;

  // Inductor current ramps only while the switch conducts
  always_ff @(posedge clk) begin
    if (gate_on !== 1'b1) begin
      on_cnt_r <= 8'h00;
    end else if (on_cnt_r != 8'hff) begin
      on_cnt_r <= on_cnt_r + 8'h01;
    end
  end

  // Lower level is crossed earlier on the same ramp; sense is at ground when off
  assign cs_above_max = (gate_on === 1'b1) && (on_cnt_r >= ramp_cyc);
  assign cs_above_min = (gate_on === 1'b1) && ({1'b0, on_cnt_r} + 9'h008 >= {1'b0, ramp_cyc});
endmodule : power_stage_model

// File: dv/power_stage_fault_manager_test.sv
`timescale 1ns/100ps
module power_stage_fault_manager_test;
  import fault_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwm_request = 1'b0, high_line = 1'b0, supply_above_clamp = 1'b0;
  logic thermal_hot = 1'b0, thermal_cooled = 1'b0, haversine_end = 1'b0;
  logic uvlo_ok = 1'b1, setting_phase = 1'b1, sense_set_b = 1'b0;
  logic [9:0] fin = 10'h000;
  logic [3:0] address = 4'h0;
  logic read = 1'b0, write = 1'b0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, gate_on, supply_sink_en, sense_source_en, irq, cs_above_max, cs_above_min;
  logic [7:0] ramp_cyc = 8'hc8;
  int errors = 0, checks_done = 0, cyc = 0;

  always #5 clk = ~clk;

  // Short debounce counts keep the run small
  power_stage_fault_manager #(.SUPPLY_OV_CYC(8), .LINE_OV_CYC(8), .FB_UV_CYC(8), .SHORT_CYC(8),
    .OVERLOAD_CYC(8)) i_power_stage_fault_manager (.clk(clk), .rst(rst), .pwm_request(pwm_request),
    .high_line(high_line), .cs_above_max(cs_above_max), .cs_above_min(cs_above_min),
    .supply_above_clamp(supply_above_clamp), .supply_above_ov(fin[0]), .fb_above_ov_a(fin[5]),
    .fb_above_ov_b(fin[6]), .fb_below_uv(fin[1]), .cs_below_short(fin[2]), .comp_above_2v(fin[2]),
    .cs_above_open(fin[9]), .comp_above_overload(fin[3]), .cs_above_otp(fin[7]),
    .thermal_hot(thermal_hot), .thermal_cooled(thermal_cooled), .haversine_end(haversine_end),
    .line_overvoltage(fin[4]), .uvlo_ok(uvlo_ok), .setting_phase(setting_phase),
    .sense_set_b(sense_set_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .gate_on(gate_on),
    .supply_sink_en(supply_sink_en), .sense_source_en(sense_source_en), .irq(irq));

  power_stage_model i_power_stage_model (.clk(clk), .gate_on(gate_on), .ramp_cyc(ramp_cyc),
    .cs_above_max(cs_above_max), .cs_above_min(cs_above_min));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    // Only the bench timeout ends a wait that never answers
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask : wr

  task automatic hiccup;
    uvlo_ok <= 1'b0;
    repeat (3) @(posedge clk);
    uvlo_ok <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : hiccup

  // One switching cycle; returns the on-time in clocks
  task automatic sw_pulse(output int w);
    int n;
    w = 0;
    n = 0;
    pwm_request <= 1'b1;
    while (gate_on !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    while (gate_on === 1'b1 && w < 300) begin
      @(posedge clk);
      w++;
    end
    pwm_request <= 1'b0;
    haversine_end <= 1'b1;
    @(posedge clk);
    haversine_end <= 1'b0;
    repeat (160) @(posedge clk);
  endtask : sw_pulse

  task automatic reg_case;
    logic [31:0] d;
    rd(ADDR_CTRL, d);
    chk("ctrl reset", CTRL_RESET, d);
    rd(ADDR_IRQ_MASK, d);
    chk("mask reset", {21'h0, MASK_RESET}, d);
    rd(ADDR_STATUS, d);
    chk("status idle", 32'h0, d);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    wr(ADDR_IRQ_MASK, 32'hffff_ffff);
    rd(ADDR_IRQ_MASK, d);
    chk("mask rw", 32'h7ff, d);
    chk("sense source", 32'h1, {31'h0, sense_source_en});
    supply_above_clamp <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sink on", 32'h1, {31'h0, supply_sink_en});
    supply_above_clamp <= 1'b0;
    repeat (3) @(posedge clk);
    chk("sink off", 32'h0, {31'h0, supply_sink_en});
  endtask : reg_case

  task automatic peak_case;
    int w;
    ramp_cyc <= 8'h05;
    sw_pulse(w);
    chk("blanked width", 32'h1, {31'h0, w >= 45 && w <= 49});
    ramp_cyc <= 8'h3c;
    sw_pulse(w);
    chk("low line width", 32'h1, {31'h0, w >= 59 && w <= 63});
    high_line <= 1'b1;
    sw_pulse(w);
    chk("high line width", 32'h1, {31'h0, w >= 51 && w <= 55});
    high_line <= 1'b0;
  endtask : peak_case

  task automatic fault_case(input int idx, input int hic, input int sw, input int ramp, input bit clr);
    logic [31:0] d;
    logic [31:0] m;
    int i, w;
    m = 32'h1 << idx;
    if (idx == 8) wr(ADDR_CTRL, 32'h1);
    rd(ADDR_IRQ_STAT, d);
    ramp_cyc <= ramp[7:0];
    fin[idx] <= 1'b1;
    if (sw == 0) repeat (3) @(posedge clk);
    for (i = 1; i < sw; i++) sw_pulse(w);
    // One pulse short of the count, or three clocks into a debounce, must not trip
    if (idx != 9) begin
      rd(ADDR_STATUS, d);
      chk("cause early", 32'h0, d & m);
    end
    if (sw > 0) sw_pulse(w);
    i = 0;
    while (irq !== 1'b1 && i < 400) begin
      @(posedge clk);
      i++;
    end
    rd(ADDR_IRQ_STAT, d);
    chk("irq cause", m, d & 32'h3ff);
    rd(ADDR_STATUS, d);
    chk("fault hold", m | 32'h400, d & 32'hf7ff);
    pwm_request <= 1'b1;
    repeat (20) @(posedge clk);
    chk("gate held", 32'h0, {31'h0, gate_on});
    pwm_request <= 1'b0;
    ramp_cyc <= 8'hc8;
    if (!clr) fin[idx] <= 1'b0;
    for (i = 1; i < hic; i++) hiccup;
    if (clr) hiccup;
    rd(ADDR_STATUS, d);
    chk("hiccup count", 32'h400 | (32'(hic - (clr ? 0 : 1)) << 12), d & 32'hf400);
    fin[idx] <= 1'b0;
    if (!clr) hiccup;
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, d);
    chk("released", 32'h0, d & 32'hf400);
    if (idx == 8) wr(ADDR_CTRL, 32'h0);
  endtask : fault_case

  task automatic thermal_case;
    logic [31:0] d;
    wr(ADDR_IRQ_MASK, 32'h0);
    thermal_hot <= 1'b1;
    pwm_request <= 1'b1;
    repeat (20) @(posedge clk);
    chk("gate stopped", 32'h0, {31'h0, gate_on});
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ADDR_STATUS, d);
    chk("thermal stop", 32'h800, d & 32'h800);
    wr(ADDR_IRQ_MASK, 32'h400);
    repeat (3) @(posedge clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rd(ADDR_IRQ_STAT, d);
    chk("irq thermal", 32'h400, d);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    thermal_hot <= 1'b0;
    thermal_cooled <= 1'b1;
    repeat (10) @(posedge clk);
    chk("gate resumed", 32'h1, {31'h0, gate_on});
    pwm_request <= 1'b0;
    thermal_cooled <= 1'b0;
  endtask : thermal_case

  // Mid-run reset re-enters the setting phase with the high-resistance set
  task automatic set_b_case;
    logic [31:0] d;
    int w;
    rst <= 1'b1;
    setting_phase <= 1'b1;
    sense_set_b <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    setting_phase <= 1'b0;
    sense_set_b <= 1'b0;
    ramp_cyc <= 8'h3c;
    fin[5] <= 1'b1;
    repeat (4) sw_pulse(w);
    rd(ADDR_STATUS, d);
    chk("set b status", 32'h10000, d);
    fin[6] <= 1'b1;
    repeat (4) sw_pulse(w);
    rd(ADDR_STATUS, d);
    chk("set b trip", 32'h10420, d);
    fin[5] <= 1'b0;
    fin[6] <= 1'b0;
    hiccup;
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, d);
    chk("set b release", 32'h10000, d);
  endtask : set_b_case

  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Whole sequence needs about 20000 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    setting_phase <= 1'b0;
    reg_case;
    peak_case;
    fault_case(0, 1, 0, 200, 1'b1);
    fault_case(1, 4, 0, 200, 1'b0);
    fault_case(2, 8, 0, 200, 1'b1);
    fault_case(3, 4, 0, 200, 1'b0);
    fault_case(4, 1, 0, 200, 1'b1);
    fault_case(9, 1, 0, 200, 1'b1);
    fault_case(5, 1, 4, 60, 1'b1);
    fault_case(6, 8, 7, 5, 1'b0);
    fault_case(7, 1, 32, 60, 1'b0);
    fault_case(8, 8, 28, 60, 1'b0);
    thermal_case;
    set_b_case;
    tally_and_finish;
  end
endmodule : power_stage_fault_manager_test
